// File: kpsd_col_filter.v
/*
 * Input conditioner: a three-stage synchroniser per bit followed by an
 * optional glitch filter that accepts a level only after it has stood for
 * FILT cycles. Assumes inputs idle high (pulled up) and an asynchronous
 * active-high reset.
 */
`timescale 1ns/1ps
module kpsd_col_filter #(
   parameter W    = 8,
   parameter FILT = 2
) (
   // Clock and reset.
   input  wire         clk_sys_in,
   input  wire         rst_in,
   // Control.
   input  wire         filter_enable_in,
   // Raw pins and conditioned levels.
   input  wire [W-1:0] raw_in,
   output wire [W-1:0] level_out
);

   genvar g;

   // One conditioner per bit; the first stage feeds only the second.
   generate
      for (g = 0; g < W; g = g + 1) begin : bit_g
         reg       s1;
         reg       s2;
         reg       s3;
         reg       val;
         reg [3:0] cnt;
         always @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
               s1  <= 1'b1;
               s2  <= 1'b1;
               s3  <= 1'b1;
               val <= 1'b1;
               cnt <= 4'h0;
            end else begin
               s1 <= raw_in[g];
               s2 <= s1;
               s3 <= s2;
               // A new level counts once stages two and three agree.
               if (s2 == s3 && s3 != val) begin
                  if (!filter_enable_in || cnt >= FILT - 1) begin // R17
                     val <= s3;
                     cnt <= 4'h0;
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end else begin
                  cnt <= 4'h0;                  // A short pulse restarts the count.
               end
            end
         end
         assign level_out[g] = val;
      end
   endgenerate

endmodule

// File: kpsd_event_queue.v
/*
 * Key event queue: a pending mask and a state bit for each of the 64 key
 * codes. Each pop returns the lowest pending code next. Assumes pops come
 * from same-clock logic, one cycle wide, at least two cycles apart.
 */
`timescale 1ns/1ps
`include "kpsd_regs.vh"
module kpsd_event_queue (
   // Clock and reset.
   input  wire        clk_sys_in,
   input  wire        rst_in,
   // Load of a fresh set of events.
   input  wire        load_in,
   input  wire [63:0] load_mask_in,
   input  wire [63:0] load_state_in,
   // Pop of the event on show.
   input  wire        pop_in,
   // Head of queue.
   output reg  [7:0]  status_byte_out,
   output reg         empty_out
);

   reg  [63:0] pend;
   reg  [63:0] kst;
   reg  [5:0]  head;
   reg  [63:0] next_pend;
   reg  [63:0] next_kst;
   reg  [5:0]  next_head;
   reg  [63:0] rest;
   integer     i;

   // Next contents; a load replaces everything, discarding old events.
   always @* begin
      next_pend = pend;
      next_kst  = kst;
      if (load_in) begin
         next_pend = load_mask_in;                    // R13
         next_kst  = load_state_in;
      end else if (pop_in && |pend) begin
         next_pend = pend & ~(64'h1 << head);
      end
      // Lowest pending code goes first.
      next_head = 6'h00;
      for (i = 63; i >= 0; i = i - 1) begin
         if (next_pend[i]) begin
            next_head = i[5:0];                       // R7
         end
      end
      rest = next_pend & ~(64'h1 << next_head);
   end

   // Registered head byte; an empty queue reads as all zeros.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pend            <= 64'h0;
         kst             <= 64'h0;
         head            <= 6'h00;
         status_byte_out <= `KPSD_ST_RESET;
         empty_out       <= 1'b1;
      end else begin
         pend      <= next_pend;
         kst       <= next_kst;
         head      <= next_head;
         empty_out <= ~|next_pend;
         if (|next_pend) begin
            status_byte_out <= {|rest, next_kst[next_head], next_head}; // R22
         end else begin
            status_byte_out <= `KPSD_ST_RESET;                         // R23
         end
      end
   end

endmodule

// File: kpsd_keypad_model.sv
/*
 * Model of the 8x8 key matrix on the far side of the scan core.
 * Assumes columns pulled up and key codes {column, row} as the core uses.
 */
`timescale 1ns/1ps
module kpsd_keypad_model (
   // Row drives from the core and keys held closed by the bench.
   input  wire [7:0]  row_drive_in,
   input  wire [63:0] keys_in,
   // Pulled-up column lines.
   output reg  [7:0]  column_sense_out
);
   integer c;
   integer r;
   // A closed key pulls its column low only while its row is driven low.
   always @* begin
      column_sense_out = 8'hff;
      for (c = 0; c < 8; c = c + 1) begin
         for (r = 0; r < 8; r = r + 1) begin
            if (keys_in[c * 8 + r] && !row_drive_in[r]) begin
               column_sense_out[c] = 1'b0;
            end
         end
      end
   end
endmodule

// File: kpsd_keypad_scan.v
/*
 * Key-scan core for an 8x8 switch matrix: row drive, column sensing,
 * three-scan debounce, event queue, alert with auto-clear, long-press
 * rescan and standby. Assumes configuration and the status read strobe come
 * from logic on clk_sys_in; column pins and the bus reset pin are asynchronous.
 */
`timescale 1ns/1ps
`include "kpsd_regs.vh"
// Operation
// R1: Code is column index then row index.
// R2: Same-column multiple presses keep only first.
// R3: Three scans with waits confirm each change.
// R4: Select bit picks 6/8ms or 3/4ms waits.
// R5: Mismatching scans abort silently to standby.
// R6: Agreeing scans queue events, then alert low.
// R7: Reads give events in ascending code order.
// R8: Alert stays low until queue drained.
// R9: Keypad changes ignored while alert low.
// R10: Drained queue returns core to standby.
// R11: Auto-clear field: off, 5ms or 10ms.
// R12: Auto-clear keeps queued events readable.
// R13: New event after auto-clear overwrites queue.
// R14: Status readable at any time.
// R15: Long-press rescans and re-alerts while held.
// R16: Long-press rescan waits the selected delay.
// R17: Optional filter drops column glitches under 100ns.
// R18: Bus reset stops bus, leaves alert alone.
// R19: Power-on reset restores every default.
// R20: Standby when bus idle, rows low.
// R21: Host reads until more flag is zero.
// R22: Status byte: more, pressed, six-bit code.
// R23: Last read clears byte and releases alert.
// R24: Long-press delay codes 20ms,40ms,1s,2s.
// R25: Internal clock times delays; one row low.
module kpsd_keypad_scan #(
   parameter DB1_SLOW_CYC = `KPSD_DB1_SLOW_CYC,
   parameter DB2_SLOW_CYC = `KPSD_DB2_SLOW_CYC,
   parameter DB1_FAST_CYC = `KPSD_DB1_FAST_CYC,
   parameter DB2_FAST_CYC = `KPSD_DB2_FAST_CYC,
   parameter AC5_CYC      = `KPSD_AC5_CYC,
   parameter AC10_CYC     = `KPSD_AC10_CYC,
   parameter LP20_CYC     = `KPSD_LP20_CYC,
   parameter LP40_CYC     = `KPSD_LP40_CYC,
   parameter LP1S_CYC     = `KPSD_LP1S_CYC,
   parameter LP2S_CYC     = `KPSD_LP2S_CYC
) (
   // Clock and reset.
   input  wire       clk_sys_in,
   input  wire       rst_in,
   // Matrix pins.
   output reg  [7:0] row_drive_out,
   input  wire [7:0] column_sense_in,
   // Configuration.
   input  wire       debounce_select_in,
   input  wire       long_press_enable_in,
   input  wire [1:0] long_press_delay_in,
   input  wire [1:0] alert_autoclear_sel_in,
   input  wire       input_filter_enable_in,
   // Host side.
   input  wire       bus_reset_n_in,
   input  wire       bus_idle_in,
   input  wire       status_read_in,
   output wire [7:0] status_byte_out,
   output reg        alert_n_out,
   output reg        bus_stopped_out,
   output reg        standby_out
);

   localparam TW = 32;
   localparam [TW-1:0] T_DB1S = DB1_SLOW_CYC;
   localparam [TW-1:0] T_DB2S = DB2_SLOW_CYC;
   localparam [TW-1:0] T_DB1F = DB1_FAST_CYC;
   localparam [TW-1:0] T_DB2F = DB2_FAST_CYC;
   localparam [TW-1:0] T_AC5  = AC5_CYC;
   localparam [TW-1:0] T_AC10 = AC10_CYC;
   localparam [TW-1:0] T_LP20 = LP20_CYC;
   localparam [TW-1:0] T_LP40 = LP40_CYC;
   localparam [TW-1:0] T_LP1S = LP1S_CYC;
   localparam [TW-1:0] T_LP2S = LP2S_CYC;
   localparam [TW-1:0] T_SETL = `KPSD_SETTLE_CYC;
   localparam [3:0]    G_SETL = T_SETL[3:0];

   // One-hot states.
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_SCAN  = 6'h02;
   localparam [5:0] ST_CHECK = 6'h04;
   localparam [5:0] ST_WAIT  = 6'h08;
   localparam [5:0] ST_ALERT = 6'h10;
   localparam [5:0] ST_HOLD  = 6'h20;

   reg  [5:0]    state;
   reg  [1:0]    pass;
   reg  [2:0]    row_idx;
   reg  [TW-1:0] timer;
   reg  [3:0]    guard;
   reg  [63:0]   scan_now;
   reg  [63:0]   snap;
   reg  [63:0]   accepted;
   reg           lp_scan;
   reg           read_seen;
   reg  [TW-1:0] t_ac;
   reg  [TW-1:0] t_lp;
   wire [7:0]    col_level;
   wire          bus_rst_n;
   wire [63:0]   masked;
   wire [7:0]    cols_exp;
   wire [63:0]   ev_mask;
   wire [TW-1:0] t_db1;
   wire [TW-1:0] t_db2;
   wire          rd_ok;
   wire          q_empty;
   wire          q_load;
   wire          col_change;
   wire          ac_on;
   integer       c;

   // Column pins pass the synchroniser and the optional glitch filter.
   kpsd_col_filter #(
      .W    (8),
      .FILT (`KPSD_GLITCH_CYC)
   ) u_col (
      .clk_sys_in       (clk_sys_in),
      .rst_in           (rst_in),
      .filter_enable_in (input_filter_enable_in),
      .raw_in           (column_sense_in),
      .level_out        (col_level)
   );

   // The bus reset pin only needs synchronising, so its filter is off.
   kpsd_col_filter #(
      .W    (1),
      .FILT (1)
   ) u_brst (
      .clk_sys_in       (clk_sys_in),
      .rst_in           (rst_in),
      .filter_enable_in (1'b0),
      .raw_in           (bus_reset_n_in),
      .level_out        (bus_rst_n)
   );

   // Per column: keep the key already accepted, else the lowest new row.
   // The matrix cannot tell two keys on one column apart without ghosting.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : col_g
         wire [7:0] cur  = scan_now[g*8 +: 8];
         wire [7:0] held = cur & accepted[g*8 +: 8];
         assign masked[g*8 +: 8] = |held ? held : (cur & (~cur + 8'h01)); // R2
         assign cols_exp[g]      = |accepted[g*8 +: 8];
      end
   endgenerate

   // Debounce waits follow the select bit.
   assign t_db1 = debounce_select_in ? T_DB1F : T_DB1S;               // R4
   assign t_db2 = debounce_select_in ? T_DB2F : T_DB2S;               // R4

   // Auto-clear and long-press delay selection.
   always @* begin
      case (alert_autoclear_sel_in)
         `KPSD_AC_5MS:  t_ac = T_AC5;                                 // R11
         `KPSD_AC_10MS: t_ac = T_AC10;                                // R11
         default:       t_ac = T_AC5;
      endcase
      case (long_press_delay_in)
         `KPSD_LP_20MS: t_lp = T_LP20;                                // R24
         `KPSD_LP_40MS: t_lp = T_LP40;                                // R24
         `KPSD_LP_1S:   t_lp = T_LP1S;                                // R24
         default:       t_lp = T_LP2S;                                // R24
      endcase
   end

   // Code 11 is not a documented auto-clear time, so it leaves it off.
   assign ac_on = (alert_autoclear_sel_in == `KPSD_AC_5MS) ||
                  (alert_autoclear_sel_in == `KPSD_AC_10MS);

   // New events: changed keys, plus every held key on a long-press rescan.
   assign ev_mask = (masked ^ accepted) | (lp_scan ? masked : 64'h0);
   assign q_load  = (state == ST_CHECK) && (pass == 2'h2) &&
                    (scan_now == snap) && |ev_mask;                   // R6

   // Reads are served in any state while the bus is out of reset.
   assign rd_ok = status_read_in && bus_rst_n;                        // R14

   // With every row low, a column's level shows any key on it.
   assign col_change = (guard == 4'h0) && ((~col_level) != cols_exp);

   kpsd_event_queue u_queue (
      .clk_sys_in      (clk_sys_in),
      .rst_in          (rst_in),
      .load_in         (q_load),
      .load_mask_in    (ev_mask),
      .load_state_in   (masked),
      .pop_in          (rd_ok),
      .status_byte_out (status_byte_out),
      .empty_out       (q_empty)
   );

   // Bus stop flag and standby flag.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         bus_stopped_out <= 1'b1;                                     // R19
         standby_out     <= 1'b1;
      end else begin
         bus_stopped_out <= ~bus_rst_n;                               // R18
         standby_out     <= (state == ST_IDLE) && bus_idle_in && !col_change; // R20
      end
   end

   // Scan sequencer, debounce and alert control.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state         <= ST_IDLE;                                    // R19
         pass          <= 2'h0;
         row_idx       <= 3'h0;
         timer         <= {TW{1'b0}};
         guard         <= G_SETL;
         scan_now      <= 64'h0;
         snap          <= 64'h0;
         accepted      <= 64'h0;
         lp_scan       <= 1'b0;
         read_seen     <= 1'b0;
         alert_n_out   <= 1'b1;
         row_drive_out <= 8'h00;
      end else begin
         if (guard != 4'h0) begin
            guard <= guard - 4'h1;
         end
         if (timer != {TW{1'b0}}) begin
            timer <= timer - {{(TW-1){1'b0}}, 1'b1};                  // R25
         end
         case (state)
            ST_IDLE: begin
               row_drive_out <= 8'h00;                                // R20
               if (col_change) begin
                  state         <= ST_SCAN;                           // R3
                  pass          <= 2'h0;
                  lp_scan       <= 1'b0;
                  row_idx       <= 3'h0;
                  timer         <= T_SETL;
                  row_drive_out <= 8'hfe;
               end
            end
            ST_HOLD: begin
               row_drive_out <= 8'h00;
               if (col_change || timer == {TW{1'b0}}) begin
                  state         <= ST_SCAN;                           // R15
                  pass          <= 2'h0;
                  lp_scan       <= ~col_change;
                  row_idx       <= 3'h0;
                  timer         <= T_SETL;
                  row_drive_out <= 8'hfe;
               end
            end
            ST_SCAN: begin
               if (timer == {TW{1'b0}}) begin
                  // Sample every column for the row now held low.
                  for (c = 0; c < 8; c = c + 1) begin
                     scan_now[c*8 + row_idx] <= ~col_level[c];        // R1
                  end
                  if (row_idx == 3'h7) begin
                     state         <= ST_CHECK;
                     row_drive_out <= 8'hff;
                  end else begin
                     row_idx       <= row_idx + 3'h1;
                     timer         <= T_SETL;
                     row_drive_out <= ~(8'h01 << (row_idx + 3'h1));   // R25
                  end
               end
            end
            ST_CHECK: begin
               if (pass == 2'h0) begin
                  snap  <= scan_now;
                  pass  <= 2'h1;
                  timer <= t_db1;                                     // R4
                  state <= ST_WAIT;
               end else if (scan_now != snap) begin
                  state <= ST_IDLE;                                   // R5
                  guard <= G_SETL;
               end else if (pass == 2'h1) begin
                  pass  <= 2'h2;
                  timer <= t_db2;                                     // R4
                  state <= ST_WAIT;
               end else if (|ev_mask) begin
                  accepted    <= masked;                              // R6
                  alert_n_out <= 1'b0;                                // R6
                  read_seen   <= 1'b0;
                  timer       <= t_ac;
                  state       <= ST_ALERT;
               end else begin
                  state <= ST_IDLE;
                  guard <= G_SETL;
               end
            end
            ST_WAIT: begin
               row_drive_out <= 8'h00;
               if (timer == {TW{1'b0}}) begin
                  state         <= ST_SCAN;                           // R3
                  row_idx       <= 3'h0;
                  timer         <= T_SETL;
                  row_drive_out <= 8'hfe;
               end
            end
            ST_ALERT: begin
               // Keypad changes are not looked at in this state.
               row_drive_out <= 8'h00;                                // R9
               if (rd_ok) begin
                  read_seen <= 1'b1;
               end
               if (q_empty || (ac_on && !read_seen && !rd_ok &&
                               timer == {TW{1'b0}})) begin
                  // Auto-clear leaves the queue as it is.
                  alert_n_out <= 1'b1;                                // R8 R12
                  guard       <= G_SETL;
                  if (long_press_enable_in && |accepted) begin
                     state <= ST_HOLD;                                // R15
                     timer <= t_lp;                                   // R16
                  end else begin
                     state <= ST_IDLE;                                // R10
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// File: kpsd_keypad_scan_bench.sv
/*
 * Self-checking bench for the key-scan core: a table of key events, then
 * hand cases. Assumes the shortened delay counts given at the instance.
 */
`timescale 1ns/1ps
module kpsd_keypad_scan_bench;
   reg         clk_sys_in = 1'b0, rst_in = 1'b1, rd = 1'b0, db_sel = 1'b0;
   reg         lp_en = 1'b0, filt = 1'b0, bus_rst_n = 1'b1, idle = 1'b1;
   reg  [1:0]  lp_dly = 2'h0, ac_sel = 2'h0;
   reg  [63:0] keys = 64'h0;
   reg  [13:0] tab [0:7];
   wire [7:0]  rows, cols, status;
   wire        alert_n, stopped, standby;
   integer     mismatches = 0, comparisons = 0, waited, lat, slow, n;
   // A 50 ns period gives the 20 MHz core clock.
   always #25 clk_sys_in = ~clk_sys_in;
   localparam D1S = 200, D2S = 300, D1F = 100, D2F = 150, AC5 = 2000, AC10 = 4000;
   localparam LP0 = 1000, LP1 = 1500, LP2 = 2000, LP3 = 2500;
   kpsd_keypad_scan #(.DB1_SLOW_CYC(D1S), .DB2_SLOW_CYC(D2S), .DB1_FAST_CYC(D1F),
      .DB2_FAST_CYC(D2F), .AC5_CYC(AC5), .AC10_CYC(AC10), .LP20_CYC(LP0),
      .LP40_CYC(LP1), .LP1S_CYC(LP2), .LP2S_CYC(LP3)) uut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .row_drive_out(rows),
      .column_sense_in(cols), .debounce_select_in(db_sel), .long_press_enable_in(lp_en),
      .long_press_delay_in(lp_dly), .alert_autoclear_sel_in(ac_sel),
      .input_filter_enable_in(filt), .bus_reset_n_in(bus_rst_n), .bus_idle_in(idle),
      .status_read_in(rd), .status_byte_out(status), .alert_n_out(alert_n),
      .bus_stopped_out(stopped), .standby_out(standby));
   kpsd_keypad_model model (.row_drive_in(rows), .keys_in(keys), .column_sense_out(cols));
   // Compare and count; an unknown never matches.
   task check(input [7:0] seen, input [7:0] want);
      begin
         comparisons = comparisons + 1;
         if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Settle 1 ns past the edge so sampled outputs have landed.
   task step;
      begin
         @(posedge clk_sys_in);
         #1;
      end
   endtask
   // Bounded wait for an alert level; a required one that never comes ends the run.
   task wait_alert(input lvl, input must);
      begin
         waited = 0;
         while (alert_n !== lvl && waited < 6000) begin
            step;
            waited = waited + 1;
         end
         if (alert_n !== lvl && must) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: alert wait ran out", $time);
            report_and_stop;
         end
      end
   endtask
   // One host read: the byte is checked, then popped with a one-cycle strobe.
   task take(input [7:0] want);
      begin
         check(status, want);
         @(posedge clk_sys_in);
         rd <= 1'b1;
         @(posedge clk_sys_in);
         rd <= 1'b0;
         step;
      end
   endtask
   // Flip keys, then drain the one or two expected events and check the byte is clear.
   task pair(input [63:0] m, input [7:0] b1, input [7:0] b2);
      begin
         @(posedge clk_sys_in);
         keys <= keys ^ m;
         step;
         wait_alert(1'b0, 1'b1);
         lat = waited;
         take(b1);
         if (b2 != 8'h00)
            take(b2);
         check(status, 8'h00);
         wait_alert(1'b1, 1'b1);
      end
   endtask
   initial begin
      tab[0] = {6'h19, 8'h59};
      tab[1] = {6'h34, 8'h74};
      tab[2] = {6'h19, 8'h19};
      tab[3] = {6'h34, 8'h34};
      tab[4] = {6'h00, 8'h40};
      tab[5] = {6'h00, 8'h00};
      tab[6] = {6'h3f, 8'h7f};
      tab[7] = {6'h3f, 8'h3f};
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (10) step;
      check({alert_n, stopped, standby, |rows, 4'h0} | status, 8'ha0);
      @(posedge clk_sys_in);
      idle <= 1'b0;
      step;
      step;
      check({7'h0, standby}, 8'h00);
      @(posedge clk_sys_in);
      idle <= 1'b1;
      for (n = 0; n < 8; n = n + 1)
         pair(64'h1 << tab[n][13:8], tab[n][7:0], 8'h00);
      pair(64'h0800000400000000, 8'he2, 8'h7b);
      pair(64'h0800000400000000, 8'ha2, 8'h3b);
      pair(64'h0000000000280000, 8'h53, 8'h00);
      pair(64'h0000000000280000, 8'h13, 8'h00);
      @(posedge clk_sys_in);
      pair(64'h20, 8'h45, 8'h00);
      slow = lat;
      @(posedge clk_sys_in);
      db_sel <= 1'b1;
      pair(64'h20, 8'h05, 8'h00);
      check({7'h0, slow - lat == 250}, 8'h01);
      // A press that goes away before the second scan must leave nothing.
      @(posedge clk_sys_in);
      keys[9] <= 1'b1;
      repeat (120) @(posedge clk_sys_in);
      keys[9] <= 1'b0;
      wait_alert(1'b0, 1'b0);
      check({alert_n, status[6:0]}, 8'h80);
      @(posedge clk_sys_in);
      filt <= 1'b1;
      keys[17] <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      keys[17] <= 1'b0;
      repeat (12) step;
      check({7'h0, standby}, 8'h01);
      wait_alert(1'b0, 1'b0);
      check({7'h0, alert_n}, 8'h01);
      for (n = 1; n < 3; n = n + 1) begin
         @(posedge clk_sys_in);
         ac_sel <= n[1:0];
         keys[42] <= 1'b1;
         step;
         wait_alert(1'b0, 1'b1);
         wait_alert(1'b1, 1'b1);
         check({7'h0, waited > AC5 * n - 20 && waited < AC5 * n + 20}, 8'h01);
         check(status, 8'h6a);
         pair(64'h1 << 42, 8'h2a, 8'h00);
      end
      for (n = 0; n < 4; n = n + 1) begin
         @(posedge clk_sys_in);
         ac_sel <= 2'h0;
         lp_en <= 1'b1;
         lp_dly <= n[1:0];
         keys[7] <= 1'b1;
         step;
         wait_alert(1'b0, 1'b1);
         take(8'h47);
         wait_alert(1'b1, 1'b1);
         wait_alert(1'b0, 1'b1);
         check({7'h0, waited >= 1000 + 500 * n && waited < 1800 + 500 * n}, 8'h01);
         @(posedge clk_sys_in);
         lp_en <= 1'b0;
         keys[7] <= 1'b0;
         take(8'h47);
         check(status, 8'h00);
         wait_alert(1'b1, 1'b1);
         wait_alert(1'b0, 1'b1);
         take(8'h07);
         wait_alert(1'b1, 1'b1);
      end
      // Bus reset must leave the alert and queue alone; core reset clears them.
      @(posedge clk_sys_in);
      keys[48] <= 1'b1;
      step;
      wait_alert(1'b0, 1'b1);
      @(posedge clk_sys_in);
      bus_rst_n <= 1'b0;
      repeat (8) step;
      check({7'h0, stopped}, 8'h01);
      take(8'h70);
      check({alert_n, status[6:0]}, 8'h70);
      @(posedge clk_sys_in);
      rst_in <= 1'b1;
      @(posedge clk_sys_in);
      rst_in <= 1'b0;
      step;
      check({alert_n, status[6:0]}, 8'h80);
      report_and_stop;
   end
endmodule

// File: kpsd_keypad_scan_sva.sv
/*
 * Concurrent checks on the ports of the key-scan core.
 * Assumes one clock domain and the active-high core reset.
 */
`timescale 1ns/1ps
module kpsd_keypad_scan_sva (
   // Clock and reset.
   input wire       clk_sys_in,
   input wire       rst_in,
   // Watched ports.
   input wire [7:0] row_drive_out,
   input wire [1:0] alert_autoclear_sel_in,
   input wire       bus_reset_n_in,
   input wire       status_read_in,
   input wire [7:0] status_byte_out,
   input wire       alert_n_out,
   input wire       bus_stopped_out,
   input wire       standby_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // Reads that pop the last event, or one with more behind it.
   sequence s_last;
      status_read_in && !bus_stopped_out && status_byte_out != 8'h00 && !status_byte_out[7];
   endsequence
   sequence s_more;
      status_read_in && !bus_stopped_out && status_byte_out[7];
   endsequence
   chk_rows_standby: assert property (standby_out |-> row_drive_out == 8'h00)
      else $error("rows driven in standby");
   chk_one_row: assert property (row_drive_out != 8'h00 |-> $countones(row_drive_out) >= 7)
      else $error("more than one row low");
   chk_row_hold: assert property ($countones(row_drive_out) == 7 && $changed(row_drive_out) |=> $stable(row_drive_out)[*8])
      else $error("row not held for a full sample");
   chk_last_clear: assert property (s_last |=> status_byte_out == 8'h00)
      else $error("status byte not cleared");
   chk_alert_free: assert property (s_last ##0 !alert_n_out |-> ##2 alert_n_out)
      else $error("alert not released after drain");
   chk_alert_hold: assert property (!alert_n_out && alert_autoclear_sel_in == 2'h0 && status_byte_out != 8'h00 && !status_read_in |=> !alert_n_out)
      else $error("alert dropped early");
   chk_drain_order: assert property (s_more |=> status_byte_out[5:0] > $past(status_byte_out[5:0]))
      else $error("events out of order");
   chk_bus_stop: assert property ($fell(bus_reset_n_in) |-> ##[1:6] bus_stopped_out)
      else $error("bus not stopped");
endmodule
bind kpsd_keypad_scan kpsd_keypad_scan_sva chk (.*);

// File: kpsd_regs.vh
/*
 * Constants of the keypad scan and debounce core: status byte layout,
 * configuration codes and timing figures with their cycle counts.
 * Assumes a 20 MHz core clock; the cycle counts follow from KPSD_CLK_MHZ.
 */
`ifndef KPSD_REGS_VH
`define KPSD_REGS_VH

// Core clock rate.
`define KPSD_CLK_MHZ        20

// Status byte fields.
`define KPSD_ST_MORE_BIT    7
`define KPSD_ST_PRESS_BIT   6
`define KPSD_ST_CODE_MSB    5
`define KPSD_ST_RESET       8'h00

// Auto-clear selection codes.
`define KPSD_AC_OFF         2'h0
`define KPSD_AC_5MS         2'h1
`define KPSD_AC_10MS        2'h2

// Long-press delay codes.
`define KPSD_LP_20MS        2'h0
`define KPSD_LP_40MS        2'h1
`define KPSD_LP_1S          2'h2

// Times in microseconds or nanoseconds, as specified.
`define KPSD_DB1_SLOW_US    6000
`define KPSD_DB2_SLOW_US    8000
`define KPSD_DB1_FAST_US    3000
`define KPSD_DB2_FAST_US    4000
`define KPSD_AC5_US         5000
`define KPSD_AC10_US        10000
`define KPSD_LP20_US        20000
`define KPSD_LP40_US        40000
`define KPSD_LP1S_US        1000000
`define KPSD_LP2S_US        2000000
`define KPSD_GLITCH_NS      100

// Derived cycle counts; the glitch window is a least time and rounds up.
`define KPSD_DB1_SLOW_CYC   (`KPSD_DB1_SLOW_US * `KPSD_CLK_MHZ)
`define KPSD_DB2_SLOW_CYC   (`KPSD_DB2_SLOW_US * `KPSD_CLK_MHZ)
`define KPSD_DB1_FAST_CYC   (`KPSD_DB1_FAST_US * `KPSD_CLK_MHZ)
`define KPSD_DB2_FAST_CYC   (`KPSD_DB2_FAST_US * `KPSD_CLK_MHZ)
`define KPSD_AC5_CYC        (`KPSD_AC5_US * `KPSD_CLK_MHZ)
`define KPSD_AC10_CYC       (`KPSD_AC10_US * `KPSD_CLK_MHZ)
`define KPSD_LP20_CYC       (`KPSD_LP20_US * `KPSD_CLK_MHZ)
`define KPSD_LP40_CYC       (`KPSD_LP40_US * `KPSD_CLK_MHZ)
`define KPSD_LP1S_CYC       (`KPSD_LP1S_US * `KPSD_CLK_MHZ)
`define KPSD_LP2S_CYC       (`KPSD_LP2S_US * `KPSD_CLK_MHZ)
`define KPSD_GLITCH_CYC     ((`KPSD_GLITCH_NS * `KPSD_CLK_MHZ + 999) / 1000)

// Cycles a row is driven before the columns are sampled.
`define KPSD_SETTLE_CYC     8

`endif
